// *** inc/prb_pkg.sv ***
// constants and carrier types for the program counter / relative branch unit
// assumes one core clock and a fetch stage that reports each instruction
// Overview of operation
// - no branch: counter advances by instruction length
// - executed branch loads destination instead of increment
// - displacement byte is signed, bit 7 sign
// - target is next instruction address plus displacement
// - displacement sign-extended across upper address bits
// - relative target for unconditional and conditional branches
package prb_pkg;
	localparam int PRB_ADDR_W = 16;
	localparam int PRB_LEN_W = 3;
	localparam int PRB_DISP_W = 8;
	localparam int PRB_SIGN_BIT = 7;
	localparam logic [PRB_ADDR_W-1:0] PRB_PC_RESET = 16'h0000;

	typedef enum logic [1:0] {
		PRB_KIND_SEQ,
		PRB_KIND_REL_UNCOND,
		PRB_KIND_REL_COND,
		PRB_KIND_ABS
	} prb_kind_e;

	// one fetched instruction as reported by the decode stage
	typedef struct packed {
		logic valid;
		logic [PRB_LEN_W-1:0] length;
		prb_kind_e kind;
		logic taken;
		logic [PRB_DISP_W-1:0] relative_displacement_byte;
		logic [PRB_ADDR_W-1:0] abs_target;
	} prb_instr_s;
endpackage

// *** hdl/prb_pc_unit.sv ***
// program counter next-address logic with relative branch target
// assumes instr_in comes from decode logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module prb_pc_unit
	import prb_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// decoded instruction
	input wire prb_instr_s instr_in,
	// counter outputs
	output logic [PRB_ADDR_W-1:0] program_counter_out,
	output logic branched_out
);
	logic [PRB_ADDR_W-1:0] program_counter_q;
	logic [PRB_ADDR_W-1:0] program_counter_d;
	logic branched_q;
	logic branched_d;
	wire [PRB_ADDR_W-1:0] next_seq;
	wire [PRB_ADDR_W-1:0] disp_ext;
	wire [PRB_ADDR_W-1:0] rel_target;
	wire is_rel;
	wire do_branch;

	// sum truncated to sixteen bits
	assign next_seq = program_counter_q
		+ PRB_ADDR_W'(instr_in.length);
	// low byte is the displacement itself, its top bit is the sign
	assign disp_ext[PRB_DISP_W-1:0] =
		instr_in.relative_displacement_byte;
	// every upper address bit copies the sign
	for (genvar b = PRB_DISP_W; b < PRB_ADDR_W; b++) begin : g_sign_ext
		assign disp_ext[b] =
			instr_in.relative_displacement_byte[PRB_SIGN_BIT];
	end
	assign rel_target = next_seq + disp_ext;
	assign is_rel = (instr_in.kind == PRB_KIND_REL_UNCOND)
		|| (instr_in.kind == PRB_KIND_REL_COND);
	// unconditional relative jump always branches
	assign do_branch = (instr_in.kind == PRB_KIND_REL_UNCOND)
		|| (instr_in.kind != PRB_KIND_SEQ && instr_in.taken);
	assign program_counter_d = !instr_in.valid ? program_counter_q
		: !do_branch ? next_seq
		: is_rel ? rel_target
		: instr_in.abs_target;
	assign branched_d = instr_in.valid && do_branch;

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			program_counter_q <= PRB_PC_RESET;
			branched_q <= 1'b0;
		end else begin
			program_counter_q <= program_counter_d;
			branched_q <= branched_d;
		end
	end

	assign program_counter_out = program_counter_q;
	assign branched_out = branched_q;

	sequence s_rel_taken;
		instr_in.valid && is_rel && do_branch;
	endsequence

	property p_seq_advance;
		@(posedge clk_sys_in) disable iff (rst_in)
		instr_in.valid && !do_branch |=> program_counter_q ==
			PRB_ADDR_W'($past(program_counter_q)
			+ PRB_ADDR_W'($past(instr_in.length)));
	endproperty
	a_seq_advance: assert property (p_seq_advance)
		else $error("sequential advance wrong");

	property p_rel_target;
		@(posedge clk_sys_in) disable iff (rst_in)
		s_rel_taken |=> program_counter_q == PRB_ADDR_W'(
			$past(program_counter_q) + PRB_ADDR_W'($past(instr_in.length))
			+ PRB_ADDR_W'(signed'($past(
			instr_in.relative_displacement_byte))));
	endproperty
	a_rel_target: assert property (p_rel_target)
		else $error("relative target wrong");

	property p_sign_ext;
		@(posedge clk_sys_in) disable iff (rst_in)
		instr_in.valid |-> disp_ext == PRB_ADDR_W'(signed'(
			instr_in.relative_displacement_byte));
	endproperty
	a_sign_ext: assert property (p_sign_ext)
		else $error("sign extension wrong");

	property p_neg_disp;
		@(posedge clk_sys_in) disable iff (rst_in)
		(s_rel_taken
			and instr_in.relative_displacement_byte[PRB_SIGN_BIT])
			|-> PRB_ADDR_W'(rel_target - next_seq) >= 16'hFF80;
	endproperty
	a_neg_disp: assert property (p_neg_disp)
		else $error("negative displacement treated as unsigned");

	property p_abs_load;
		@(posedge clk_sys_in) disable iff (rst_in)
		instr_in.valid && do_branch && !is_rel
			|=> program_counter_q == $past(instr_in.abs_target)
			&& branched_out;
	endproperty
	a_abs_load: assert property (p_abs_load)
		else $error("branch destination not loaded");

	property p_uncond;
		@(posedge clk_sys_in) disable iff (rst_in)
		instr_in.valid && instr_in.kind == PRB_KIND_REL_UNCOND
			|=> branched_out;
	endproperty
	a_uncond: assert property (p_uncond)
		else $error("unconditional relative jump not taken");

	property p_hold;
		@(posedge clk_sys_in) disable iff (rst_in)
		!instr_in.valid |=> $stable(program_counter_q) && !branched_out;
	endproperty
	a_hold: assert property (p_hold)
		else $error("counter moved without instruction");

	property p_wrap;
		@(posedge clk_sys_in) disable iff (rst_in)
		instr_in.valid && !do_branch && program_counter_q == 16'hFFFF
			&& instr_in.length == 3'h1 |=> program_counter_q == 16'h0000;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("counter did not wrap");

	// instructions that only advance the counter
	sequence s_seq_instr;
		instr_in.valid && instr_in.kind == PRB_KIND_SEQ;
	endsequence

	sequence s_cond_taken;
		instr_in.valid && instr_in.kind == PRB_KIND_REL_COND
			&& instr_in.taken;
	endsequence

	sequence s_cond_skip;
		instr_in.valid && instr_in.kind == PRB_KIND_REL_COND
			&& !instr_in.taken;
	endsequence

	// a branch followed by an idle cycle
	sequence s_branch_then_idle;
		instr_in.valid && do_branch ##1 !instr_in.valid;
	endsequence

	// two sequential instructions back to back
	sequence s_seq_pair;
		s_seq_instr ##1 s_seq_instr;
	endsequence

	property p_seq_no_branch;
		@(posedge clk_sys_in) disable iff (rst_in)
		s_seq_instr |=> !branched_out && program_counter_q ==
			PRB_ADDR_W'($past(program_counter_q)
			+ PRB_ADDR_W'($past(instr_in.length)));
	endproperty
	a_seq_no_branch: assert property (p_seq_no_branch)
		else $error("sequential instruction branched");

	property p_seq_pair;
		@(posedge clk_sys_in) disable iff (rst_in)
		s_seq_pair |=> program_counter_q == PRB_ADDR_W'(
			$past(program_counter_q, 2)
			+ PRB_ADDR_W'($past(instr_in.length, 2))
			+ PRB_ADDR_W'($past(instr_in.length)));
	endproperty
	a_seq_pair: assert property (p_seq_pair)
		else $error("back to back sequential advance wrong");

	property p_cond_taken;
		@(posedge clk_sys_in) disable iff (rst_in)
		s_cond_taken |=> branched_out && program_counter_q == PRB_ADDR_W'(
			$past(program_counter_q) + PRB_ADDR_W'($past(instr_in.length))
			+ PRB_ADDR_W'(signed'($past(
			instr_in.relative_displacement_byte))));
	endproperty
	a_cond_taken: assert property (p_cond_taken)
		else $error("taken conditional branch missed its target");

	property p_cond_skip;
		@(posedge clk_sys_in) disable iff (rst_in)
		s_cond_skip |=> !branched_out && program_counter_q ==
			PRB_ADDR_W'($past(program_counter_q)
			+ PRB_ADDR_W'($past(instr_in.length)));
	endproperty
	a_cond_skip: assert property (p_cond_skip)
		else $error("untaken conditional branch moved counter wrongly");

	property p_pos_disp;
		@(posedge clk_sys_in) disable iff (rst_in)
		(s_rel_taken
			and !instr_in.relative_displacement_byte[PRB_SIGN_BIT])
			|-> PRB_ADDR_W'(rel_target - next_seq) <= 16'h007F;
	endproperty
	a_pos_disp: assert property (p_pos_disp)
		else $error("positive displacement not zero extended");

	// distance from the next instruction stays within one signed byte
	property p_reach;
		@(posedge clk_sys_in) disable iff (rst_in)
		s_rel_taken |=> PRB_ADDR_W'(program_counter_q
			- $past(program_counter_q) - PRB_ADDR_W'($past(instr_in.length))
			+ 16'h0080) <= 16'h00FF;
	endproperty
	a_reach: assert property (p_reach)
		else $error("relative branch outside signed byte reach");

	property p_flag_pulse;
		@(posedge clk_sys_in) disable iff (rst_in)
		s_branch_then_idle |=> !branched_out;
	endproperty
	a_flag_pulse: assert property (p_flag_pulse)
		else $error("branch flag stood longer than one cycle");
endmodule // prb_pc_unit
`default_nettype wire

// *** tb/prb_fetch_model.sv ***
// fetch/decode stage model feeding decoded instructions to the unit
// assumes the bench hands it one request per core clock cycle
`timescale 1ns/1ps
`default_nettype none
module prb_fetch_model
	import prb_pkg::*;
(
	// request from bench
	input wire prb_instr_s req_in,
	// towards the unit
	output wire prb_instr_s instr_out
);
	// idle cycles carry a scrambled payload, never a stale copy
	assign instr_out = req_in.valid ? req_in : {1'b0, ~req_in[29:0]};
endmodule // prb_fetch_model
`default_nettype wire

// *** tb/test_pc_relative_branch_unit.sv ***
// self-checking bench for the program counter unit
// assumes the fetch model in tb/ and the unit in hdl/
`timescale 1ns/1ps
`default_nettype none
module test_pc_relative_branch_unit
	import prb_pkg::*;
;
	typedef struct packed {prb_instr_s i; logic [15:0] pc; logic br;} prb_row_s;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	prb_instr_s req = '0;
	wire prb_instr_s instr;
	logic [15:0] pc;
	logic br;
	int err_count = 0;
	int tests_run = 0;
	// instruction beside the counter and branch flag it should give
	prb_row_s rows [8] = '{
		'{'{1'b1, 3'h3, PRB_KIND_SEQ, 1'b1, 8'h00, 16'h0000}, 16'h0003, 1'b0},
		'{'{1'b1, 3'h2, PRB_KIND_REL_UNCOND, 1'b0, 8'h7F, 16'h0000}, 16'h0084, 1'b1},
		'{'{1'b1, 3'h2, PRB_KIND_REL_COND, 1'b1, 8'h80, 16'h0000}, 16'h0006, 1'b1},
		'{'{1'b1, 3'h2, PRB_KIND_REL_COND, 1'b0, 8'h80, 16'h0000}, 16'h0008, 1'b0},
		'{'{1'b1, 3'h3, PRB_KIND_ABS, 1'b1, 8'h00, 16'hFFFE}, 16'hFFFE, 1'b1},
		'{'{1'b1, 3'h4, PRB_KIND_SEQ, 1'b0, 8'h00, 16'h0000}, 16'h0002, 1'b0},
		'{'{1'b1, 3'h2, PRB_KIND_REL_COND, 1'b1, 8'hFC, 16'h0000}, 16'h0000, 1'b1},
		'{'{1'b1, 3'h2, PRB_KIND_REL_UNCOND, 1'b0, 8'h80, 16'h0000}, 16'hFF82, 1'b1}};
	always #2.5 clk_sys_in = ~clk_sys_in;
	prb_fetch_model model (.req_in(req), .instr_out(instr));
	prb_pc_unit DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.instr_in(instr), .program_counter_out(pc), .branched_out(br));
	task automatic chk(input string name, input logic [15:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wrap_up;
		if (err_count == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		#1 chk("pc_reset", pc, 16'h0000);
		for (int n = 0; n <= 8; n++) begin
			@(posedge clk_sys_in);
			if (n < 8) req <= rows[n].i;
			else req.valid <= 1'b0;
			#1;
			if (n > 0) begin
				chk("pc", pc, rows[n-1].pc);
				chk("branched", {15'h0000, br}, {15'h0000, rows[n-1].br});
			end
		end
		@(posedge clk_sys_in);
		#1 chk("pc_hold", pc, 16'hFF82);
		chk("branched_idle", {15'h0000, br}, 16'h0000);
		// reset in mid-run wins over a branch presented while it stands
		@(posedge clk_sys_in);
		req <= rows[1].i;
		rst_in <= 1'b1;
		#1 chk("pc_midreset", pc, 16'h0000);
		@(posedge clk_sys_in);
		rst_in <= 1'b0;
		#1 chk("pc_after_reset", pc, 16'h0000);
		// first edge after release takes the waiting branch: 0 + 2 + 7F
		@(posedge clk_sys_in);
		req <= '{1'b1, 3'h3, PRB_KIND_ABS, 1'b1, 8'h00, 16'hFFFF};
		#1 chk("pc_first", pc, 16'h0081);
		chk("branched_first", {15'h0000, br}, 16'h0001);
		@(posedge clk_sys_in);
		req <= '{1'b1, 3'h1, PRB_KIND_SEQ, 1'b1, 8'h00, 16'h0000};
		#1 chk("pc_abs", pc, 16'hFFFF);
		@(posedge clk_sys_in);
		req.length <= 3'h2;
		#1 chk("pc_wrap", pc, 16'h0000);
		chk("branched_seq", {15'h0000, br}, 16'h0000);
		@(posedge clk_sys_in);
		req.valid <= 1'b0;
		#1 chk("pc_pair", pc, 16'h0002);
		wrap_up();
	end
endmodule // test_pc_relative_branch_unit
`default_nettype wire
